// [rtl/cpu_program_register_file.sv]
// program register set: general registers, program counter, shift and bit unit
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - there are thirty-two 32-bit general registers, each usable as data or address operand.
// - general register 0 always reads as zero.
// - register 30 is the implicit base address for short-format load and store.
// - the program counter keeps only its low 26 bits, bits 31 to 26 read as zero.
// - a carry out of bit 25 while stepping or adding to the counter is dropped.
// - bit 0 of the program counter is always zero, so no odd branch target exists.
// - program addresses span 64 MB linear and data addresses span 4 GB linear.
// - a full 32-bit shift completes in one clock cycle.
// - four bit operations exist: set, clear, invert and test a bit.
module cpu_program_register_file
    import prog_regs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire logic [IDX_W-1:0]    rd_a_idx,
    input  wire logic [IDX_W-1:0]    rd_b_idx,
    input  wire logic                wr_en,
    input  wire logic [IDX_W-1:0]    wr_idx,
    input  wire logic [DATA_W-1:0]   wr_data,
    input  wire logic                short_mem_instr,
    input  wire logic [DATA_W-1:0]   short_disp,
    input  wire alu_op_e             alu_op,
    input  wire logic [DATA_W-1:0]   alu_src,
    input  wire logic [SHAMT_W-1:0]  alu_amt,
    input  wire pc_op_e              pc_op,
    input  wire logic [DATA_W-1:0]   pc_operand,
    output logic [DATA_W-1:0]        rd_a_data,
    output logic [DATA_W-1:0]        rd_b_data,
    output logic [DATA_W-1:0]        short_addr,
    output logic [DATA_W-1:0]        alu_result,
    output logic                     bit_zero_flag,
    output logic                     alu_valid,
    output logic [DATA_W-1:0]        pc
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // read port with the zero register forced, used by both ports
    function automatic logic [DATA_W-1:0] read_reg(
        input logic [DATA_W-1:0] regs [NUM_REGS],
        input logic [IDX_W-1:0]  idx
    );
        read_reg = (idx == ZERO_IDX) ? ZERO_WORD : regs[idx];
    endfunction

    // clamp any counter value to the valid even 26-bit range
    function automatic logic [DATA_W-1:0] pc_clamp(input logic [DATA_W-1:0] v);
        pc_clamp = v & PC_MASK;
    endfunction

    // one-hot select of the addressed bit
    function automatic logic [DATA_W-1:0] bit_select(input logic [SHAMT_W-1:0] n);
        bit_select = ONE_WORD << n;
    endfunction

    // zero flag reports the bit as it was before the operation
    function automatic logic bit_was_clear(
        input logic [DATA_W-1:0] v,
        input logic [DATA_W-1:0] mask
    );
        bit_was_clear = ~|(v & mask);
    endfunction

    // ------------------------------------------------------------
    // general registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] gpr_q [NUM_REGS];
    logic [DATA_W-1:0] gpr_d [NUM_REGS];

    // slot 0 keeps a flop so every slot decodes alike; it never loads
    genvar g;
    generate
        for (g = 0; g < NUM_REGS; g++) begin : gen_gpr
            always_comb begin
                gpr_d[g] = gpr_q[g];
                if (IDX_W'(g) == ZERO_IDX) begin
                    gpr_d[g] = ZERO_WORD;
                end else if (wr_en && wr_idx == IDX_W'(g)) begin
                    gpr_d[g] = wr_data;
                end
            end
            always_ff @(posedge clk) begin
                if (reset) begin
                    gpr_q[g] <= ZERO_WORD;
                end else begin
                    gpr_q[g] <= gpr_d[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // registered read ports
    // ------------------------------------------------------------
    logic [DATA_W-1:0] rd_a_d;
    logic [DATA_W-1:0] rd_b_d;

    // no forwarding: a write on this edge reads out one cycle later
    always_comb begin
        rd_a_d = read_reg(gpr_q, rd_a_idx);
        rd_b_d = read_reg(gpr_q, rd_b_idx);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rd_a_data <= ZERO_WORD;
            rd_b_data <= ZERO_WORD;
        end else begin
            rd_a_data <= rd_a_d;
            rd_b_data <= rd_b_d;
        end
    end

    // ------------------------------------------------------------
    // short-format address
    // ------------------------------------------------------------
    logic [DATA_W-1:0] short_addr_d;

    // holds between short accesses so the last address stays visible
    always_comb begin
        short_addr_d = short_addr;
        if (short_mem_instr) begin
            // 32-bit wrap is the 4 GB data space
            short_addr_d = gpr_q[ELEM_IDX] + short_disp;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            short_addr <= ZERO_WORD;
        end else begin
            short_addr <= short_addr_d;
        end
    end

    // ------------------------------------------------------------
    // shift and bit unit
    // ------------------------------------------------------------
    logic [DATA_W-1:0] alu_result_d;
    logic              bit_zero_d;
    logic              alu_valid_d;
    logic [DATA_W-1:0] bit_mask;

    always_comb begin
        bit_mask     = bit_select(alu_amt);
        alu_result_d = alu_result;
        bit_zero_d   = bit_zero_flag;
        alu_valid_d  = 1'b1;
        case (alu_op)
            // barrel shifter, no iteration, result next edge
            OP_SHL: alu_result_d = alu_src << alu_amt;
            OP_SHR: alu_result_d = alu_src >> alu_amt;
            OP_SAR: alu_result_d = $unsigned($signed(alu_src) >>> alu_amt);
            OP_BIT_SET: begin
                bit_zero_d   = bit_was_clear(alu_src, bit_mask);
                alu_result_d = alu_src | bit_mask;
            end
            OP_BIT_CLEAR: begin
                bit_zero_d   = bit_was_clear(alu_src, bit_mask);
                alu_result_d = alu_src & ~bit_mask;
            end
            OP_BIT_INVERT: begin
                bit_zero_d   = bit_was_clear(alu_src, bit_mask);
                alu_result_d = alu_src ^ bit_mask;
            end
            OP_BIT_TEST: begin
                // test leaves the operand unchanged, only the flag moves
                bit_zero_d   = bit_was_clear(alu_src, bit_mask);
                alu_result_d = alu_src;
            end
            // idle cycles drop valid but keep result and flag
            OP_NONE: alu_valid_d = 1'b0;
            default: alu_valid_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            alu_result    <= ZERO_WORD;
            bit_zero_flag <= 1'b0;
            alu_valid     <= 1'b0;
        end else begin
            alu_result    <= alu_result_d;
            bit_zero_flag <= bit_zero_d;
            alu_valid     <= alu_valid_d;
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    logic [DATA_W-1:0] pc_d;
    logic [DATA_W-1:0] pc_addend;

    always_comb begin
        // one adder serves both the step and the relative add
        pc_addend = (pc_op == PC_INC) ? PC_STEP : pc_operand;
        pc_d      = pc;
        case (pc_op)
            PC_HOLD: pc_d = pc;
            // a carry past bit 25 is masked away, not trapped
            PC_INC:  pc_d = pc_clamp(pc + pc_addend);
            PC_ADD:  pc_d = pc_clamp(pc + pc_addend);
            PC_LOAD: pc_d = pc_clamp(pc_operand);
            default: pc_d = pc;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            pc <= PC_RESET;
        end else begin
            pc <= pc_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/prog_regs_pkg.sv]
// constants for the program register file
`default_nettype none
package prog_regs_pkg;
    localparam int unsigned DATA_W       = 32;
    localparam int unsigned NUM_REGS     = 32;
    localparam int unsigned IDX_W        = 5;
    localparam int unsigned PC_W         = 26;
    localparam int unsigned SHAMT_W      = 5;
    localparam logic [4:0]  ZERO_IDX     = 5'h0;
    localparam logic [4:0]  ELEM_IDX     = 5'h1e;
    localparam logic [31:0] ZERO_WORD    = 32'h0000_0000;
    localparam logic [31:0] PC_RESET     = 32'h0000_0000;
    localparam logic [31:0] PC_STEP      = 32'h0000_0004;
    localparam logic [31:0] PC_MASK      = 32'h03ff_fffe;
    localparam logic [31:0] ONE_WORD     = 32'h0000_0001;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_SHL,
        OP_SHR,
        OP_SAR,
        OP_BIT_SET,
        OP_BIT_CLEAR,
        OP_BIT_INVERT,
        OP_BIT_TEST
    } alu_op_e;

    typedef enum logic [1:0] {
        PC_HOLD,
        PC_INC,
        PC_ADD,
        PC_LOAD
    } pc_op_e;
endpackage

`default_nettype wire

// [verif/cpu_program_register_file_tb.sv]
// self-checking bench for the program register file
`timescale 1ns/1ps
`default_nettype none
module cpu_program_register_file_tb;
    import prog_regs_pkg::*;
    typedef struct packed {logic [4:0] idx; logic [31:0] data; logic [31:0] exp;} row_s;
    logic        clk = 0, reset = 1, wr_en = 0, short_mem_instr = 0, bit_zero_flag, alu_valid;
    logic [4:0]  rd_a_idx = 0, rd_b_idx = 0, wr_idx = 0, alu_amt = 0;
    logic [31:0] wr_data = 0, short_disp = 0, alu_src = 0, pc_operand = 0;
    logic [31:0] rd_a_data, rd_b_data, short_addr, alu_result, pc;
    alu_op_e     alu_op = OP_NONE;
    pc_op_e      pc_op = PC_HOLD;
    int          failures = 0, total_checks = 0;
    row_s        rows [4] = '{'{5'h01, 32'hdead_beef, 32'hdead_beef}, '{5'h00, 32'hffff_ffff, 32'h0000_0000},
                              '{5'h1f, 32'h8000_0001, 32'h8000_0001}, '{5'h1e, 32'h0000_1000, 32'h0000_1000}};
    cpu_program_register_file DUT (.clk, .reset, .rd_a_idx, .rd_b_idx, .wr_en, .wr_idx, .wr_data, .short_mem_instr,
        .short_disp, .alu_op, .alu_src, .alu_amt, .pc_op, .pc_operand, .rd_a_data, .rd_b_data, .short_addr,
        .alu_result, .bit_zero_flag, .alu_valid, .pc);
    initial forever #2 clk = ~clk;
    // ----
    // shared tasks
    // ----
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    // idle after one edge; settle before looking
    task automatic cyc;
        @(posedge clk);
        wr_en <= 0;
        short_mem_instr <= 0;
        alu_op <= OP_NONE;
        pc_op <= PC_HOLD;
        #1;
    endtask
    task automatic alu(input alu_op_e op, input logic [31:0] src, input logic [4:0] amt, input logic [31:0] exp);
        @(posedge clk);
        alu_op <= op;
        alu_src <= src;
        alu_amt <= amt;
        cyc;
        chk("valid", {31'h0, alu_valid}, 32'h0000_0001);
        if (op == OP_BIT_TEST) chk("flag", {31'h0, bit_zero_flag}, exp);
        else chk("alu", alu_result, exp);
    endtask
    task automatic end_sim;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge clk);
        failures++;
        end_sim;
    end
    initial begin
        repeat (8) @(posedge clk);
        reset <= 0;
        foreach (rows[i]) begin
            @(posedge clk);
            wr_en <= 1;
            wr_idx <= rows[i].idx;
            wr_data <= rows[i].data;
            rd_a_idx <= rows[i].idx;
            cyc;
            cyc;
            chk("rd_a", rd_a_data, rows[i].exp);
            chk("rd_b", rd_b_data, ZERO_WORD);
        end
        @(posedge clk);
        rd_b_idx <= 5'h1f;
        cyc;
        chk("rd_b_port", rd_b_data, 32'h8000_0001);
        $display("rows done");
        @(posedge clk);
        short_mem_instr <= 1;
        short_disp <= 32'hffff_f004;
        rd_a_idx <= ELEM_IDX;
        cyc;
        chk("short", short_addr, 32'h0000_0004);
        @(posedge clk);
        pc_op <= PC_LOAD;
        pc_operand <= 32'hffff_ffff;
        cyc;
        chk("pc_load", pc, 32'h03ff_fffe);
        @(posedge clk);
        pc_op <= PC_INC;
        cyc;
        chk("pc_wrap", pc, 32'h0000_0002);
        @(posedge clk);
        pc_op <= PC_ADD;
        pc_operand <= 32'h0000_0003;
        cyc;
        chk("pc_add", pc, 32'h0000_0004);
        $display("pc done");
        alu(OP_SHL, 32'h8000_0001, 5'h1f, 32'h8000_0000);
        alu(OP_SHR, 32'h8000_0001, 5'h1f, 32'h0000_0001);
        alu(OP_SAR, 32'h8000_0000, 5'h1f, 32'hffff_ffff);
        alu(OP_BIT_SET, 32'h0000_00f0, 5'h03, 32'h0000_00f8);
        alu(OP_BIT_CLEAR, 32'h0000_00f0, 5'h04, 32'h0000_00e0);
        alu(OP_BIT_INVERT, 32'h0000_00f0, 5'h1f, 32'h8000_00f0);
        alu(OP_BIT_TEST, 32'h0000_00f0, 5'h04, 32'h0000_0000);
        alu(OP_BIT_TEST, 32'h0000_00f0, 5'h03, 32'h0000_0001);
        cyc;
        chk("idle_valid", {31'h0, alu_valid}, 32'h0000_0000);
        chk("idle_hold", alu_result, 32'h0000_00f0);
        $display("alu done");
        @(posedge clk);
        reset <= 1;
        rd_a_idx <= 5'h01;
        cyc;
        @(posedge clk);
        reset <= 0;
        cyc;
        chk("rst_pc", pc, PC_RESET);
        chk("rst_reg", rd_a_data, ZERO_WORD);
        $display("reset done");
        end_sim;
    end
endmodule
`default_nettype wire

// [verif/prog_regs_assertions.sv]
// checker for the program register file
`timescale 1ns/1ps
`default_nettype none
module prog_regs_checker
    import prog_regs_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [4:0]  rd_a_idx,
    input wire logic [4:0]  rd_b_idx,
    input wire logic [31:0] rd_a_data,
    input wire logic [31:0] rd_b_data,
    input wire logic        short_mem_instr,
    input wire logic [31:0] short_disp,
    input wire logic [31:0] short_addr,
    input wire alu_op_e     alu_op,
    input wire logic [31:0] alu_src,
    input wire logic [4:0]  alu_amt,
    input wire logic [31:0] alu_result,
    input wire logic        alu_valid,
    input wire pc_op_e      pc_op,
    input wire logic [31:0] pc_operand,
    input wire logic [31:0] pc
);
    // ----
    // one clock domain, so one default
    // ----
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_pc_upper_zero: assert property (pc[31:26] == 6'h00) else $error("pc upper bits set");
    a_pc_even: assert property (pc[0] == 1'b0) else $error("pc odd");
    a_zero_a_read: assert property (rd_a_idx == ZERO_IDX |=> rd_a_data == ZERO_WORD)
        else $error("zero reg a");
    a_zero_b_read: assert property (rd_b_idx == ZERO_IDX |=> rd_b_data == ZERO_WORD)
        else $error("zero reg b");
    a_pc_step_wrap: assert property (pc_op == PC_INC |=> pc == (($past(pc) + PC_STEP) & PC_MASK))
        else $error("pc step");
    a_pc_load_mask: assert property (pc_op == PC_LOAD |=> pc == ($past(pc_operand) & PC_MASK))
        else $error("pc load");
    a_shift_one_cycle: assert property (
        alu_op == OP_SHL |=> alu_valid && alu_result == ($past(alu_src) << $past(alu_amt)))
        else $error("shift");
    a_bit_set_op: assert property (
        alu_op == OP_BIT_SET |=> alu_result == ($past(alu_src) | (ONE_WORD << $past(alu_amt))))
        else $error("bit set");
    a_short_base: assert property (
        short_mem_instr && rd_a_idx == ELEM_IDX |=> short_addr == rd_a_data + $past(short_disp))
        else $error("short base");
    c_bit_test: cover property (alu_op == OP_BIT_TEST);
    c_pc_add: cover property (pc_op == PC_ADD);
    c_short: cover property (short_mem_instr);
endmodule
bind cpu_program_register_file prog_regs_checker u_chk (.clk, .reset, .rd_a_idx, .rd_b_idx, .rd_a_data, .rd_b_data,
    .short_mem_instr, .short_disp, .short_addr, .alu_op, .alu_src, .alu_amt, .alu_result, .alu_valid, .pc_op,
    .pc_operand, .pc);
`default_nettype wire
